/* src/cscr_top.sv */
// Control logic of the clock generator: watchdog-guarded frequency change, PLL programming,
// strap latching, spread-spectrum settings and bus clock stopping.
// Assumes a register master on clk and an analog PLL reporting lock asynchronously.
`include "cscr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cscr_top
    import cscr_pkg::*;
#(
    parameter int WD_UNIT_CYCLES = 20000000,
    parameter logic [6:0] DEF_MULT = 7'h40,
    parameter logic [5:0] DEF_DIV = 6'h20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Straps and PLL status pins
    input wire logic [3:0] freqStrapCode,
    input wire logic linkModeStrap66,
    input wire logic pllLockedIn,
    // Bus clock stop
    input wire logic busClockStopN,
    input wire logic busClkIn,
    // PLL control
    output logic [6:0] cpuPllMult,
    output logic [5:0] cpuPllDiv,
    output logic cpuPllLoad,
    output logic clkOutEnable,
    // Spread spectrum to CPU PLL only
    output logic cpuPllSpreadEn,
    output logic cpuPllSpreadDown,
    output logic cpuPllSpreadWide,
    output logic cpuPllSpreadUp,
    // Output gates
    output logic stoppableBusGate,
    output logic busLinkGate,
    // System reset
    output logic systemResetOutN
);
    // Ctrl, multiplier, divider and status register fields
    logic [3:0] wdSel;
    logic [3:0] softFreqSelect;
    logic pllProgramEnable;
    logic ssEn;
    logic ssDown;
    logic ssWide;
    logic [6:0] multReg;
    logic [5:0] divReg;
    logic watchdogExpiredFlag;
    // Synchronisers
    logic [2:0] lockSync;
    logic [2:0] stopSync;
    logic [2:0] busClkSync;
    logic [3:0] strapSync1;
    logic [3:0] strapSync2;
    logic link66Sync1;
    logic link66Sync2;
    logic pllLocked;
    logic stopSeen;
    logic busClkFall;
    // Strap capture
    logic [1:0] strapWait;
    logic strapsLatched;
    logic [3:0] strapCode;
    logic linkMode66;
    // Watchdog
    cscr_wd_e wdState;
    logic [31:0] unitCnt;
    logic [3:0] secCnt;
    logic [15:0] rstCnt;
    logic freqChange;
    // Frequency computation
    cscr_scale_t scale;
    logic [34:0] dividend;
    logic [34:0] quotient;
    logic [6:0] remainder;
    logic [5:0] divBits;
    logic divBusy;
    logic [31:0] cpuFreqHz;
    // Spread and bus stop
    logic [15:0] ssCnt;
    logic busStopped;

    localparam logic [15:0] RstCycles = 16'(`CSCR_RST_PULSE_CYC);
    localparam logic [15:0] SsTicks = 16'(`CSCR_SS_TICKS);

    // Scale constant for each strap code
    function automatic cscr_scale_t scaleOf(input logic [3:0] code);
        case (code)
            4'h0: scaleOf = 28'h0;
            4'h1, 4'h5: scaleOf = 28'd127994667;
            4'h4: scaleOf = 28'd95996000;
            4'h8, 4'h9: scaleOf = 28'd95966000;
            default: scaleOf = 28'd191992000;
        endcase
    endfunction : scaleOf

    wire ctrlWr = regWr && regAddr == `CSCR_OFS_CTRL;
    wire multWr = regWr && regAddr == `CSCR_OFS_MULT;
    wire divWr = regWr && regAddr == `CSCR_OFS_DIV;
    wire statWr = regWr && regAddr == `CSCR_OFS_STAT;
    wire [3:0] newFsel = regWrData[`CSCR_CTRL_SOFT_FREQ_SELECT_LSB +: 4];
    wire newPen = regWrData[`CSCR_CTRL_PEN_BIT];
    // Values the PLL takes on its next load; the frequency sum must use these, not the stale outputs
    wire [6:0] pllMultSel = pllProgramEnable ? multReg : DEF_MULT;
    wire [5:0] pllDivSel = pllProgramEnable ? divReg : DEF_DIV;

    // Programmed divider changes, soft select changes and enable changes all move the frequency
    always_comb begin
        freqChange = 1'b0;
        if (ctrlWr && (newFsel != softFreqSelect || newPen != pllProgramEnable)) begin
            freqChange = 1'b1;
        end
        if ((multWr || divWr) && pllProgramEnable) begin
            freqChange = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdSel <= 4'h0;
            softFreqSelect <= 4'h0;
            pllProgramEnable <= 1'b0;
            ssEn <= 1'b0;
            ssDown <= 1'b0;
            ssWide <= 1'b0;
        end else if (ctrlWr) begin
            wdSel <= regWrData[`CSCR_CTRL_WD_LSB +: 4];
            softFreqSelect <= newFsel;
            pllProgramEnable <= newPen;
            ssEn <= regWrData[`CSCR_CTRL_SSEN_BIT];
            ssDown <= regWrData[`CSCR_CTRL_SSDOWN_BIT];
            ssWide <= regWrData[`CSCR_CTRL_SSWIDE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            multReg <= `CSCR_MULT_RESET;
            divReg <= `CSCR_DIV_RESET;
        end else begin
            if (multWr) begin
                multReg <= regWrData[6:0];
            end
            if (divWr) begin
                divReg <= regWrData[5:0];
            end
        end
    end

    // Three-stage synchronisers; a lock or stop change counts when stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lockSync <= 3'b000;
            stopSync <= 3'b111;
            busClkSync <= 3'b000;
            pllLocked <= 1'b0;
            stopSeen <= 1'b0;
        end else begin
            lockSync <= {lockSync[1:0], pllLockedIn};
            stopSync <= {stopSync[1:0], busClockStopN};
            busClkSync <= {busClkSync[1:0], busClkIn};
            if (lockSync[1] == lockSync[2]) begin
                pllLocked <= lockSync[2];
            end
            if (stopSync[1] == stopSync[2]) begin
                stopSeen <= !stopSync[2];
            end
        end
    end

    // Bus clock falling edge seen as stage two low after stage three high
    assign busClkFall = busClkSync[2] && !busClkSync[1];

    always_ff @(posedge clk) begin
        strapSync1 <= freqStrapCode;
        strapSync2 <= strapSync1;
        link66Sync1 <= linkModeStrap66;
        link66Sync2 <= link66Sync1;
    end

    // Straps caught once after reset release, before outputs may run
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strapWait <= 2'd0;
            strapsLatched <= 1'b0;
            strapCode <= 4'h0;
            linkMode66 <= 1'b0;
        end else if (!strapsLatched) begin
            strapWait <= strapWait + 2'd1;
            if (strapWait == 2'(`CSCR_STRAP_WAIT - 1)) begin
                strapsLatched <= 1'b1;
                strapCode <= strapSync2;
                linkMode66 <= link66Sync2;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkOutEnable <= 1'b0;
        end else begin
            clkOutEnable <= strapsLatched && pllLocked && wdState != WD_SWITCH;
        end
    end

    // PLL programming: register values only while enabled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpuPllMult <= DEF_MULT;
            cpuPllDiv <= DEF_DIV;
            cpuPllLoad <= 1'b0;
        end else begin
            cpuPllLoad <= freqChange;
            cpuPllMult <= pllMultSel;
            cpuPllDiv <= pllDivSel;
        end
    end

    // Scale frozen from strap code in effect before programming
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scale <= 28'h0;
        end else if (!pllProgramEnable) begin
            scale <= scaleOf(strapCode);
        end
    end

    // Serial restoring division of scale times multiplier by divider
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dividend <= 35'h0;
            quotient <= 35'h0;
            remainder <= 7'h0;
            divBits <= 6'h0;
            divBusy <= 1'b0;
            cpuFreqHz <= 32'h0;
        end else if (cpuPllLoad) begin
            dividend <= 35'(scale) * 35'(pllMultSel);
            quotient <= 35'h0;
            remainder <= 7'h0;
            divBits <= 6'd35;
            divBusy <= pllDivSel != 6'h0;
        end else if (divBusy) begin
            dividend <= {dividend[33:0], 1'b0};
            if ({remainder[5:0], dividend[34]} >= {1'b0, cpuPllDiv}) begin
                remainder <= {remainder[5:0], dividend[34]} - {1'b0, cpuPllDiv};
                quotient <= {quotient[33:0], 1'b1};
            end else begin
                remainder <= {remainder[5:0], dividend[34]};
                quotient <= {quotient[33:0], 1'b0};
            end
            divBits <= divBits - 6'd1;
            if (divBits == 6'd1) begin
                divBusy <= 1'b0;
            end
        end else begin
            cpuFreqHz <= quotient[31:0];
        end
    end

    // Watchdog: switch first, wait for lock, then time the selected seconds
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdState <= WD_IDLE;
            unitCnt <= 32'h0;
            secCnt <= 4'h0;
            rstCnt <= 16'h0;
        end else begin
            case (wdState)
                WD_IDLE: begin
                    if (freqChange && wdSel != 4'h0) begin
                        wdState <= WD_SWITCH;
                    end
                end
                WD_SWITCH: begin
                    unitCnt <= 32'h0;
                    secCnt <= 4'h0;
                    if (wdSel == 4'h0) begin
                        wdState <= WD_IDLE;
                    end else if (!cpuPllLoad && pllLocked) begin
                        wdState <= WD_WATCH;
                    end
                end
                WD_WATCH: begin
                    if (wdSel == 4'h0) begin
                        wdState <= WD_IDLE;
                    end else if (freqChange) begin
                        wdState <= WD_SWITCH;
                    end else if (unitCnt == 32'(WD_UNIT_CYCLES - 1)) begin
                        unitCnt <= 32'h0;
                        secCnt <= secCnt + 4'h1;
                        if (secCnt + 4'h1 >= wdSel) begin
                            wdState <= WD_RESET;
                            rstCnt <= RstCycles;
                        end
                    end else begin
                        unitCnt <= unitCnt + 32'h1;
                    end
                end
                WD_RESET: begin
                    rstCnt <= rstCnt - 16'h1;
                    if (rstCnt == 16'h1) begin
                        wdState <= WD_IDLE;
                    end
                end
                default: wdState <= WD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            systemResetOutN <= 1'b1;
        end else begin
            systemResetOutN <= !(wdState == WD_RESET && rstCnt != 16'h1);
        end
    end

    // Expired flag: set wins over a write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            watchdogExpiredFlag <= 1'b0;
        end else if (wdState == WD_WATCH && unitCnt == 32'(WD_UNIT_CYCLES - 1) && secCnt + 4'h1 >= wdSel
                     && wdSel != 4'h0 && !freqChange) begin
            watchdogExpiredFlag <= 1'b1;
        end else if (statWr && regWrData[`CSCR_STAT_WDX_BIT]) begin
            watchdogExpiredFlag <= 1'b0;
        end
    end

    // Spread settings drive only the CPU PLL; fixed clocks have no spread path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ssCnt <= 16'h0;
            cpuPllSpreadUp <= 1'b0;
            cpuPllSpreadEn <= 1'b0;
            cpuPllSpreadDown <= 1'b0;
            cpuPllSpreadWide <= 1'b0;
        end else begin
            cpuPllSpreadEn <= ssEn;
            cpuPllSpreadDown <= ssDown;
            cpuPllSpreadWide <= ssWide;
            if (!ssEn || ssCnt == SsTicks - 16'h1) begin
                ssCnt <= 16'h0;
                cpuPllSpreadUp <= ssEn && !cpuPllSpreadUp;
            end else begin
                ssCnt <= ssCnt + 16'h1;
            end
        end
    end

    // Bus clock gating changes only at falling edges so outputs rest low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busStopped <= 1'b0;
        end else if (busClkFall) begin
            busStopped <= stopSeen;
        end
    end

    always_comb begin
        stoppableBusGate = clkOutEnable && !busStopped;
        busLinkGate = clkOutEnable && (linkMode66 || !busStopped);
    end

    // Register read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 32'h0;
        end else if (regRd) begin
            case (regAddr)
                `CSCR_OFS_CTRL: regRdData <= {20'h0, ssWide, ssDown, ssEn, pllProgramEnable, softFreqSelect, wdSel};
                `CSCR_OFS_MULT: regRdData <= {25'h0, multReg};
                `CSCR_OFS_DIV: regRdData <= {26'h0, divReg};
                `CSCR_OFS_STAT: regRdData <= {23'h0, linkMode66, busStopped, clkOutEnable, pllLocked, strapCode,
                                              watchdogExpiredFlag};
                `CSCR_OFS_SCALE: regRdData <= {4'h0, scale};
                `CSCR_OFS_FREQ: regRdData <= cpuFreqHz;
                default: regRdData <= 32'h0;
            endcase
        end else begin
            regRdData <= 32'h0;
        end
    end
endmodule : cscr_top
`default_nettype wire

/* src/cscr_map.svh */
// Offsets, field positions, reset values and timing counts of the clock self-recovery control block.
// Assumes a 20 MHz system clock.
// What this block does
// - Switch to the new frequency first, then start the watchdog.
// - Timeout bits rewritten to zero before expiry cancel the watchdog.
// - A new soft frequency select value also starts the watchdog.
// - On expiry pulse the reset output low and set the expired flag.
// - Scale constant comes from the strap code latched before programming.
// - CPU frequency equals scale times multiplier divided by divider.
// - Power-on latches every strap, only then may outputs be enabled.
// - Clock outputs stay off until the PLL reports lock.
// - CPU frequency from sampled straps; registers select further frequencies.
// - Spread applies to CPU pairs, all bus clocks and link clocks; this block drives spread to the CPU PLL only.
// - Reference, USB and floppy clocks never carry spread.
// - Spread offers center or down mode, 0.5% or 1.0%, 33 kHz rate.
// - Bus stop input stops all 33 MHz outputs except the free-running one.
// - Link outputs in 66 MHz mode ignore the bus stop input.
// - Stop input sampled on bus clock; outputs stop at next falling edge, low.
// - Program enable set uses register multiplier/divider, clear uses defaults.
`ifndef CSCR_MAP_SVH
`define CSCR_MAP_SVH
`define CSCR_OFS_CTRL 8'h00
`define CSCR_OFS_MULT 8'h04
`define CSCR_OFS_DIV 8'h08
`define CSCR_OFS_STAT 8'h0c
`define CSCR_OFS_SCALE 8'h10
`define CSCR_OFS_FREQ 8'h14
`define CSCR_CTRL_WD_LSB 0
`define CSCR_CTRL_SOFT_FREQ_SELECT_LSB 4
`define CSCR_CTRL_PEN_BIT 8
`define CSCR_CTRL_SSEN_BIT 9
`define CSCR_CTRL_SSDOWN_BIT 10
`define CSCR_CTRL_SSWIDE_BIT 11
`define CSCR_STAT_WDX_BIT 0
`define CSCR_CTRL_RESET 32'h0000_0000
`define CSCR_MULT_RESET 7'h00
`define CSCR_DIV_RESET 6'h00
`define CSCR_CLK_HZ 20000000
`define CSCR_SS_RATE_HZ 33000
`define CSCR_SS_TICKS ((`CSCR_CLK_HZ) / (2 * `CSCR_SS_RATE_HZ))
`define CSCR_RST_PULSE_NS 50000
`define CSCR_RST_PULSE_CYC ((`CSCR_RST_PULSE_NS * (`CSCR_CLK_HZ / 1000000)) / 1000)
`define CSCR_STRAP_WAIT 3
`endif

/* src/cscr_pkg.sv */
// Types shared by the clock self-recovery control block.
// Assumes the map header is compiled alongside.
package cscr_pkg;
    typedef enum logic [1:0] {
        WD_IDLE,
        WD_SWITCH,
        WD_WATCH,
        WD_RESET
    } cscr_wd_e;
    typedef logic [27:0] cscr_scale_t;
endpackage : cscr_pkg

/* sim/cscr_top_asserts.sv */
// Port checker for cscr_top.
// Assumes it is bound onto cscr_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cscr_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Observed ports
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [31:0] regRdData,
    input wire logic pllLockedIn,
    input wire logic busClockStopN,
    input wire logic cpuPllLoad,
    input wire logic clkOutEnable,
    input wire logic cpuPllSpreadEn,
    input wire logic cpuPllSpreadUp,
    input wire logic stoppableBusGate,
    input wire logic busLinkGate,
    input wire logic systemResetOutN
);
    logic [9:0] lowCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Length of the running reset pulse
    always_ff @(posedge clk) begin
        if (sys_rst || systemResetOutN)
            lowCnt <= 10'h000;
        else
            lowCnt <= lowCnt + 10'h001;
    end
    sequence s_lock_lost;
        !pllLockedIn [*6];
    endsequence
    a_rdata_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside read slot");
    a_load_cause: assert property (cpuPllLoad |-> $past(regWr))
        else $error("PLL load without a write");
    a_reset_width: assert property ($rose(systemResetOutN) |-> lowCnt == 10'h3e7)
        else $error("reset pulse width wrong");
    a_lock_gate: assert property (s_lock_lost |=> !clkOutEnable)
        else $error("outputs enabled without lock");
    a_gate_enable: assert property (busLinkGate |-> clkOutEnable)
        else $error("link gate open while disabled");
    a_gate_order: assert property (stoppableBusGate |-> busLinkGate)
        else $error("stoppable gate open with link gate shut");
    a_stop_cause: assert property ($fell(stoppableBusGate) && clkOutEnable |-> !$past(busClockStopN, 2))
        else $error("bus gate closed without stop");
    a_restart_cause: assert property ($rose(stoppableBusGate) && $past(clkOutEnable) |-> $past(busClockStopN, 2))
        else $error("bus gate reopened while stopped");
    a_spread_dir: assert property ($changed(cpuPllSpreadUp) |-> $past(cpuPllSpreadEn))
        else $error("spread direction moved while off");
endmodule : cscr_top_asserts

bind cscr_top cscr_top_asserts u_chk (.clk, .sys_rst, .regRd, .regWr, .regRdData, .pllLockedIn,
    .busClockStopN, .cpuPllLoad, .clkOutEnable, .cpuPllSpreadEn, .cpuPllSpreadUp, .stoppableBusGate,
    .busLinkGate, .systemResetOutN);
`default_nettype wire

/* sim/cscr_env_model.sv */
// Model of the analog PLL and the bus clock source beside cscr_top.
// Assumes every load pulse, and reset, costs the PLL its lock for LOCK_CYC cycles.
`timescale 1ns/1ps
`default_nettype none
module cscr_env_model #(
    parameter int LOCK_CYC = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // PLL control
    input wire logic cpuPllLoad,
    // Status back to the block
    output var logic pllLockedIn,
    output var logic busClkIn
);
    int lockCnt = 0;
    logic [1:0] phase = 2'h0;
    // Relock search after power-up and each reload
    always_ff @(posedge clk) begin
        if (sys_rst || cpuPllLoad)
            lockCnt <= LOCK_CYC;
        else if (lockCnt != 0)
            lockCnt <= lockCnt - 1;
    end
    // Free-running bus clock at a quarter of clk
    always_ff @(posedge clk) begin
        phase <= phase + 2'h1;
    end
    always_comb pllLockedIn = (lockCnt == 0);
    always_comb busClkIn = phase[1];
endmodule : cscr_env_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for cscr_top with the PLL and bus clock model.
// Assumes the checker binds itself; watchdog unit shortened to 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [3:0] freqStrapCode = 4'h1;
    logic linkModeStrap66 = 1'b0;
    logic busClockStopN = 1'b1;
    logic [31:0] regRdData;
    logic [31:0] d;
    logic [6:0] cpuPllMult;
    logic [5:0] cpuPllDiv;
    logic pllLockedIn, busClkIn, cpuPllLoad, clkOutEnable, cpuPllSpreadEn, cpuPllSpreadDown;
    logic cpuPllSpreadWide, cpuPllSpreadUp, stoppableBusGate, busLinkGate, systemResetOutN;
    int fail_count = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    cscr_top #(.WD_UNIT_CYCLES(10)) uut (.clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .freqStrapCode, .linkModeStrap66, .pllLockedIn, .busClockStopN, .busClkIn,
        .cpuPllMult, .cpuPllDiv, .cpuPllLoad, .clkOutEnable, .cpuPllSpreadEn, .cpuPllSpreadDown,
        .cpuPllSpreadWide, .cpuPllSpreadUp, .stoppableBusGate, .busLinkGate, .systemResetOutN);
    cscr_env_model env (.clk, .sys_rst, .cpuPllLoad, .pllLockedIn, .busClkIn);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask : rd
    function automatic logic [31:0] exp_scale(input logic [3:0] c);
        case (c)
            4'h1, 4'h5: return 32'h07a1_0b2b;
            4'h4: return 32'h05b8_c860;
            4'h8, 4'h9: return 32'h05b8_5330;
            default: return 32'h0b71_90c0;
        endcase
    endfunction : exp_scale
    task automatic do_reset(input logic [3:0] code, input logic link);
        int n;
        @(posedge clk);
        freqStrapCode <= code;
        linkModeStrap66 <= link;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (n = 0; n < 100 && clkOutEnable !== 1'b1; n++)
            @(posedge clk) #1;
        chk("enable", 32'h1, 32'(clkOutEnable));
        chk("enable_late", 32'h1, 32'(n > 2));
    endtask : do_reset
    task automatic t_regs();
        logic [7:0] adr [4] = '{8'h00, 8'h04, 8'h08, 8'h18};
        foreach (adr[i]) begin
            rd(adr[i], d);
            chk("reg_reset", 32'h0, d);
        end
        rd(8'h0c, d);
        chk("status", 32'h062, d & 32'h1ff);
        chk("mult_def", 32'h40, 32'(cpuPllMult));
        chk("div_def", 32'h20, 32'(cpuPllDiv));
        $display("regs done");
    endtask : t_regs
    task automatic t_program();
        wr(8'h04, 32'h28);
        wr(8'h08, 32'h1e);
        #1 chk("mult_def", 32'h40, 32'(cpuPllMult));
        wr(8'h00, 32'h100);
        #1 chk("load", 32'h1, 32'(cpuPllLoad));
        repeat (3) @(posedge clk) #1;
        chk("mult", 32'h28, 32'(cpuPllMult));
        chk("div", 32'h1e, 32'(cpuPllDiv));
        repeat (40) @(posedge clk);
        rd(8'h14, d);
        chk("freq", 32'(64'(exp_scale(4'h1)) * 40 / 30), d);
        wr(8'h00, 32'h0);
        repeat (3) @(posedge clk) #1;
        chk("mult_def", 32'h40, 32'(cpuPllMult));
        $display("program done");
    endtask : t_program
    task automatic t_expire();
        int n;
        int w;
        wr(8'h00, 32'h01);
        wr(8'h00, 32'h11);
        #1 chk("load", 32'h1, 32'(cpuPllLoad));
        chk("rst_hold", 32'h1, 32'(systemResetOutN));
        for (n = 0; n < 300 && systemResetOutN !== 1'b0; n++)
            @(posedge clk) #1;
        chk("wd_late", 32'h1, 32'(n > 10));
        for (w = 0; w < 1100 && systemResetOutN === 1'b0; w++)
            @(posedge clk) #1;
        chk("rst_width", 32'h3e7, w);
        rd(8'h0c, d);
        chk("wd_flag", 32'h1, d & 32'h1);
        wr(8'h0c, 32'h1);
        rd(8'h0c, d);
        chk("wd_clear", 32'h0, d & 32'h1);
        $display("expire done");
    endtask : t_expire
    task automatic t_cancel();
        int low = 0;
        wr(8'h00, 32'h22);
        wr(8'h00, 32'h20);
        repeat (200) begin
            @(posedge clk) #1;
            low += (systemResetOutN !== 1'b1);
        end
        chk("no_reset", 32'h0, low);
        rd(8'h0c, d);
        chk("wd_flag", 32'h0, d & 32'h1);
        rd(8'h00, d);
        chk("ctrl", 32'h20, d);
        $display("cancel done");
    endtask : t_cancel
    task automatic t_spread();
        int n;
        logic u;
        for (int m = 0; m < 4; m++) begin
            wr(8'h00, 32'h220 | (32'(m) << 10));
            @(posedge clk) #1;
            chk("spread", 32'h4 | 32'(m), {29'h0, cpuPllSpreadEn, cpuPllSpreadWide, cpuPllSpreadDown});
        end
        u = cpuPllSpreadUp;
        for (n = 0; n < 320 && cpuPllSpreadUp === u; n++)
            @(posedge clk) #1;
        chk("spread_dir", 32'h1, 32'(cpuPllSpreadUp !== u));
        wr(8'h00, 32'h20);
        $display("spread done");
    endtask : t_spread
    task automatic t_stop();
        for (int l = 0; l < 2; l++) begin
            do_reset(4'h1, l[0]);
            busClockStopN <= 1'b0;
            repeat (15) @(posedge clk) #1;
            chk("bus_gate", 32'h0, 32'(stoppableBusGate));
            chk("link_gate", 32'(l), 32'(busLinkGate));
            rd(8'h0c, d);
            chk("stopped", 32'h80, d & 32'h80);
            busClockStopN <= 1'b1;
            repeat (15) @(posedge clk) #1;
            chk("bus_gate", 32'h1, 32'(stoppableBusGate));
        end
        $display("stop done");
    endtask : t_stop
    task automatic t_scale();
        for (int i = 0; i < 4; i++) begin
            do_reset(4'h1 << i, 1'b0);
            rd(8'h10, d);
            chk("scale", exp_scale(4'h1 << i), d);
        end
        $display("scale done");
    endtask : t_scale
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial begin
        do_reset(4'h1, 1'b0);
        t_regs();
        t_program();
        t_expire();
        t_cancel();
        t_spread();
        t_stop();
        t_scale();
        complete_run();
    end
    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
